// >>> dv/tb.sv
`timescale 1ns/1ps
module tb;
  import sks_pkg::*;
  // ---------------------------------------------------------------------------
  // Stimulus, observation and a behavioural data memory
  // ---------------------------------------------------------------------------
  logic                  ref_clk_i = 1'b0;
  logic                  rst_i     = 1'b1;
  logic                  start_i   = 1'b0;
  sks_op_t               op_i      = SKS_OP_NONE;
  logic [SKS_ADDR_W-1:0] addr_i    = 8'h00;
  logic [SKS_BIT_W-1:0]  bit_sel_i = 3'h0;
  logic [SKS_DATA_W-1:0] mem_rdata_i;
  logic                  mem_rd_o, mem_wr_o, busy_o, skip_o, dummy_o, done_o, flags_we_o;
  logic                  rd_q = 1'b0;
  logic [SKS_ADDR_W-1:0] mem_addr_o;
  logic [SKS_DATA_W-1:0] mem_wdata_o, working_register_o;
  logic [SKS_DATA_W-1:0] mem [256];
  int                    num_errors = 0;
  int                    n_tests = 0;
  int                    cycles = 0;

  sks_skip_ops uut (.ref_clk_i, .rst_i, .start_i, .op_i, .addr_i, .bit_sel_i, .mem_rdata_i, .mem_rd_o,
    .mem_wr_o, .mem_addr_o, .mem_wdata_o, .working_register_o, .busy_o, .skip_o, .dummy_o, .done_o, .flags_we_o);

  always #12.5 ref_clk_i = ~ref_clk_i;

  // Outside a read and the cycle after it the data lines show the inverse, so an early sample is caught.
  assign mem_rdata_i = (mem_rd_o || rd_q) ? mem[mem_addr_o] : ~mem[mem_addr_o];

  always @(posedge ref_clk_i)
  begin
    rd_q <= mem_rd_o;
    if (mem_wr_o === 1'b1)
      mem[mem_addr_o] <= mem_wdata_o;
    if (!rst_i)
      chk({7'h00, flags_we_o}, 8'h00);
    cycles <= cycles + 1;
    if (cycles == 2000)
    begin
      num_errors = num_errors + 1;
      end_of_test();
    end
  end

  // ---------------------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic run_op(input sks_op_t op, input logic [7:0] adr, input logic [2:0] bs, input logic skp);
    int n = 2;
    @(posedge ref_clk_i);
    #1;
    start_i = 1'b1;
    op_i = op;
    addr_i = adr;
    bit_sel_i = bs;
    @(posedge ref_clk_i);
    #1;
    start_i = 1'b0;
    op_i = SKS_OP_NONE;
    chk({7'h00, mem_rd_o}, 8'h01);
    chk(mem_addr_o, adr);
    chk({7'h00, busy_o}, 8'h01);
    @(posedge ref_clk_i);
    #1;
    chk({6'h00, skip_o, dummy_o}, {6'h00, skp, skp});
    chk({7'h00, busy_o}, {7'h00, skp});
    while (done_o !== 1'b1 && n < 8)
    begin
      @(posedge ref_clk_i);
      #1;
      n++;
    end
    chk(8'(n), skp ? 8'h03 : 8'h02);
    @(posedge ref_clk_i);
    #1;
  endtask

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  task automatic t_inc_mem();
    mem[8'h05] = 8'hFF;
    run_op(SKS_OP_INC_MEM_SKIP_ZERO, 8'h05, 3'h0, 1'b1);
    chk(mem[8'h05], 8'h00);
    mem[8'h06] = 8'h7F;
    run_op(SKS_OP_INC_MEM_SKIP_ZERO, 8'h06, 3'h7, 1'b0);
    chk(mem[8'h06], 8'h80);
  endtask

  task automatic t_inc_wreg();
    mem[8'h09] = 8'hFF;
    run_op(SKS_OP_INC_TO_WORKING_SKIP_ZERO, 8'h09, 3'h0, 1'b1);
    chk(working_register_o, 8'h00);
    chk(mem[8'h09], 8'hFF);
    mem[8'h0A] = 8'h41;
    run_op(SKS_OP_INC_TO_WORKING_SKIP_ZERO, 8'h0A, 3'h0, 1'b0);
    chk(working_register_o, 8'h42);
    chk(mem[8'h0A], 8'h41);
  endtask

  // Mixed bit pattern 8'hA5, so each index must pick its own bit.
  task automatic t_bit();
    logic [7:0] pat = 8'hA5;
    mem[8'h20] = pat;
    for (int b = 0; b < 8; b++)
      run_op(SKS_OP_BIT_SET_SKIP, 8'h20, 3'(b), pat[b]);
    // The working register still holds the last increment, so a stray load would show.
    chk(working_register_o, 8'h42);
  endtask

  task automatic end_of_test();
    if (num_errors == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial
  begin
    for (int i = 0; i < 256; i++)
      mem[i] = 8'h00;
    repeat (8) @(posedge ref_clk_i);
    #1;
    rst_i = 1'b0;
    chk(working_register_o, SKS_WREG_RST);
    t_inc_mem();
    t_inc_wreg();
    t_bit();
    end_of_test();
  end
endmodule // tb

// >>> rtl/sks_pkg.sv
package sks_pkg;

  // ---------------------------------------------------------------------------
  // Operation codes presented by the decode stage
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0]
  {
    SKS_OP_INC_MEM_SKIP_ZERO,
    SKS_OP_INC_TO_WORKING_SKIP_ZERO,
    SKS_OP_BIT_SET_SKIP,
    SKS_OP_NONE
  } sks_op_t;

  // ---------------------------------------------------------------------------
  // Widths and constants
  // ---------------------------------------------------------------------------
  localparam int          SKS_DATA_W   = 8;
  localparam int          SKS_ADDR_W   = 8;
  localparam int          SKS_BIT_W    = 3;
  localparam logic [7:0]  SKS_ONE      = 8'h01;
  localparam logic [7:0]  SKS_ZERO     = 8'h00;
  localparam logic [7:0]  SKS_WREG_RST = 8'h00;

endpackage

// >>> rtl/sks_skip_ops.sv
`timescale 1ns/1ps
module sks_skip_ops
  import sks_pkg::*;
(
  // Clock and reset
  input  wire logic                  ref_clk_i,
  input  wire logic                  rst_i,
  // Decode stage
  input  wire logic                  start_i,
  input  wire sks_op_t               op_i,
  input  wire logic [SKS_ADDR_W-1:0] addr_i,
  input  wire logic [SKS_BIT_W-1:0]  bit_sel_i,
  // Data memory read data, used in the same cycle that mem_rd_o is high
  input  wire logic [SKS_DATA_W-1:0] mem_rdata_i,
  // Data memory port
  output logic                       mem_rd_o,
  output logic                       mem_wr_o,
  output logic [SKS_ADDR_W-1:0]      mem_addr_o,
  output logic [SKS_DATA_W-1:0]      mem_wdata_o,
  // Working register
  output logic [SKS_DATA_W-1:0]      working_register_o,
  // Sequencing toward fetch
  output logic                       busy_o,
  output logic                       skip_o,
  output logic                       dummy_o,
  output logic                       done_o,
  output logic                       flags_we_o
);

  // ---------------------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_DUMMY} sks_state_t;

  sks_state_t            state_ff;
  sks_op_t               op_ff;
  logic [SKS_BIT_W-1:0]  bit_ff;
  logic [SKS_DATA_W-1:0] nxt_sum;
  logic                  nxt_skip;

  assign nxt_sum = mem_rdata_i + SKS_ONE;

  // The skip decision is made from the read data in the execute cycle.
  always_comb
  begin
    unique case (op_ff)
      SKS_OP_INC_MEM_SKIP_ZERO:        nxt_skip = (nxt_sum == SKS_ZERO);
      SKS_OP_INC_TO_WORKING_SKIP_ZERO: nxt_skip = (nxt_sum == SKS_ZERO);
      SKS_OP_BIT_SET_SKIP:             nxt_skip = mem_rdata_i[bit_ff];
      SKS_OP_NONE:                     nxt_skip = 1'b0;
    endcase
  end

  // A start that arrives while an instruction is in flight is dropped without notice.
  // Decode must wait for done; queueing it would need a buffer that nothing here asks for.
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      state_ff <= ST_IDLE;
      op_ff    <= SKS_OP_NONE;
      bit_ff   <= '0;
    end
    else
    begin
      unique case (state_ff)
        ST_IDLE:
          if (start_i && op_i != SKS_OP_NONE)
          begin
            state_ff <= ST_EXEC;
            op_ff    <= op_i;
            bit_ff   <= bit_sel_i;
          end
        // A taken skip adds the dummy cycle, giving three cycles in all.
        ST_EXEC:  state_ff <= nxt_skip ? ST_DUMMY : ST_IDLE;
        ST_DUMMY: state_ff <= ST_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // Memory port
  // ---------------------------------------------------------------------------
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      mem_rd_o    <= 1'b0;
      mem_addr_o  <= '0;
    end
    else
    begin
      mem_rd_o <= (state_ff == ST_IDLE) && start_i && op_i != SKS_OP_NONE;
      if (state_ff == ST_IDLE && start_i)
        mem_addr_o <= addr_i;
    end
  end

  // Only the memory variant writes back; the others leave the byte alone.
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      mem_wr_o    <= 1'b0;
      mem_wdata_o <= '0;
    end
    else
    begin
      mem_wr_o <= (state_ff == ST_EXEC) && op_ff == SKS_OP_INC_MEM_SKIP_ZERO;
      if (state_ff == ST_EXEC)
        mem_wdata_o <= nxt_sum;
    end
  end

  // ---------------------------------------------------------------------------
  // Working register
  // ---------------------------------------------------------------------------
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
      working_register_o <= SKS_WREG_RST;
    else if (state_ff == ST_EXEC && op_ff == SKS_OP_INC_TO_WORKING_SKIP_ZERO)
      working_register_o <= nxt_sum;
  end

  // ---------------------------------------------------------------------------
  // Status toward fetch
  // ---------------------------------------------------------------------------
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      busy_o     <= 1'b0;
      skip_o     <= 1'b0;
      dummy_o    <= 1'b0;
      done_o     <= 1'b0;
      flags_we_o <= 1'b0;
    end
    else
    begin
      // Busy falls with done, so fetch may present the next start in the done cycle.
      busy_o     <= (state_ff == ST_IDLE) ? (start_i && op_i != SKS_OP_NONE)
                                          : (state_ff == ST_EXEC && nxt_skip);
      skip_o     <= (state_ff == ST_EXEC) && nxt_skip;
      dummy_o    <= (state_ff == ST_EXEC) && nxt_skip;
      done_o     <= (state_ff == ST_EXEC && !nxt_skip) || state_ff == ST_DUMMY;
      // Held low on purpose, so the flag logic never sees a write from these instructions.
      flags_we_o <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  // Read data is only valid while the read is outstanding, so checks that need it
  // take it through $past instead of looking at the pins a cycle late.
  AST_WRITE_BACK: assert property (mem_wr_o |-> mem_wdata_o == $past(mem_rdata_i) + SKS_ONE)
    else $error("write back is not memory plus one");
  AST_WRITE_SAME: assert property (mem_wr_o |-> $stable(mem_addr_o))
    else $error("write back address differs from read address");
  AST_READ_FIRST: assert property (mem_wr_o |-> $past(mem_rd_o))
    else $error("write back without a preceding read");
  AST_ZERO_SKIP:
    assert property (state_ff == ST_EXEC && op_ff != SKS_OP_BIT_SET_SKIP
                     && op_ff != SKS_OP_NONE && nxt_sum == SKS_ZERO |=> skip_o)
    else $error("zero result did not skip");
  AST_DUMMY_AFTER: assert property (skip_o |-> dummy_o ##1 done_o)
    else $error("dummy cycle missing after skip");
  AST_DUMMY_ONCE: assert property (dummy_o |=> !dummy_o)
    else $error("more than one dummy cycle");
  AST_DUMMY_BUSY: assert property (dummy_o |-> busy_o)
    else $error("fetch not held during dummy cycle");
  AST_THREE_CYC: assert property (mem_rd_o ##1 skip_o |-> ##1 done_o)
    else $error("taken skip not three cycles");
  AST_NO_SKIP:
    assert property (state_ff == ST_EXEC && op_ff != SKS_OP_BIT_SET_SKIP
                     && nxt_sum != SKS_ZERO |=> !skip_o && done_o)
    else $error("nonzero result skipped");
  AST_WREG_LOAD:
    assert property (state_ff == ST_EXEC && op_ff == SKS_OP_INC_TO_WORKING_SKIP_ZERO
                     |=> working_register_o == $past(nxt_sum))
    else $error("working register not memory plus one");
  AST_WREG_NO_WR:
    assert property (state_ff == ST_EXEC && op_ff != SKS_OP_INC_MEM_SKIP_ZERO
                     |=> !mem_wr_o)
    else $error("memory written by non writing op");
  AST_WREG_SKIP:
    assert property (skip_o && $past(op_ff) == SKS_OP_INC_TO_WORKING_SKIP_ZERO
                     |-> working_register_o == SKS_ZERO)
    else $error("skip with nonzero working register");
  AST_BIT_SKIP:
    assert property (state_ff == ST_EXEC && op_ff == SKS_OP_BIT_SET_SKIP
                     |=> skip_o == $past(mem_rdata_i[bit_ff]))
    else $error("bit test skip wrong");
  AST_NO_FLAGS: assert property (!flags_we_o)
    else $error("flags written");
  AST_BIT_CLR:
    assert property (state_ff == ST_EXEC && op_ff == SKS_OP_BIT_SET_SKIP
                     && !mem_rdata_i[bit_ff] |=> !dummy_o && done_o)
    else $error("dummy inserted for clear bit");

  // ---------------------------------------------------------------------------
  // Cover points
  // ---------------------------------------------------------------------------
  COV_MEM_SKIP:  cover property (skip_o && $past(op_ff) == SKS_OP_INC_MEM_SKIP_ZERO);
  COV_WREG_SKIP: cover property (skip_o && $past(op_ff) == SKS_OP_INC_TO_WORKING_SKIP_ZERO);
  COV_BIT_SKIP:  cover property (skip_o && $past(op_ff) == SKS_OP_BIT_SET_SKIP);
  COV_NO_SKIP:   cover property (done_o && !$past(dummy_o));
  COV_BIT_CLEAR: cover property (done_o && !$past(dummy_o) && $past(op_ff) == SKS_OP_BIT_SET_SKIP);

endmodule // sks_skip_ops
